// File: src/clock_mode_defines.svh
`ifndef CLOCK_MODE_DEFINES_SVH
`define CLOCK_MODE_DEFINES_SVH

// Register byte offsets on the Avalon-MM slave.
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_INT_STATUS    8'h08
`define REG_INT_MASK      8'h0C
`define REG_XTAL_BIAS     8'h10
`define REG_HFRC_TRIM     8'h14
`define REG_CAL_COUNT     8'h18
`define REG_LF_DIV        8'h1C

// Control register fields.
`define CTRL_SRC_BIT      0
`define CTRL_CPU_BIT      1
`define CTRL_LF_BIT       2
`define CTRL_XEN_BIT      3
`define CTRL_RESET        4'h2

// Status register fields.
`define STAT_SRC_BIT      0
`define STAT_FAST_BIT     1
`define STAT_FLASH_BIT    2
`define STAT_FAIL_BIT     3
`define STAT_RADIO_BIT    4
`define STAT_HEALTH_BIT   5

// Interrupt status and mask fields.
`define INT_FAIL_BIT      0
`define INT_SWITCH_BIT    1
`define INT_WIDTH         2

// Reset values of the tuning registers.
`define XTAL_BIAS_RESET   4'hF
`define HFRC_TRIM_RESET   6'h20
`define LF_INT_RESET      8'h0A
`define LF_FRAC_RESET     16'h0000

// Timing.
`define CLOCK_PERIOD_NS   20
`define XTAL_FAIL_NS      320
`define XTAL_FAIL_CYCLES  (`XTAL_FAIL_NS / `CLOCK_PERIOD_NS)
`define CAL_WINDOW        1024

`endif

// File: src/clock_mode_pkg.sv
package clock_mode_pkg;

    typedef enum logic {
        SRC_HF_RC,
        SRC_HF_CRYSTAL
    } main_system_clock_source_e;

    typedef enum logic {
        CPU_NORMAL,
        CPU_FAST
    } cpu_mode_e;

    typedef logic [31:0] bus_word_t;

endpackage : clock_mode_pkg

// File: src/crystal_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "clock_mode_defines.svh"

module crystal_monitor #(
    parameter int LIMIT = `XTAL_FAIL_CYCLES
) (
    input  wire logic i_clock,
    input  wire logic i_rst_n,
    input  wire logic i_enable,
    input  wire logic i_tick,
    output logic      o_healthy
);
    localparam int CW = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);

    logic [CW-1:0] silent;
    wire           expired = (silent == LIMIT_C);

    // A disabled crystal reads as expired so it can never be selected.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || !i_enable)
            silent <= LIMIT_C;
        else if (i_tick)
            silent <= '0;
        else if (!expired)
            silent <= silent + CW'(1);
    end

    assign o_healthy = !expired;

endmodule : crystal_monitor
`default_nettype wire

// File: src/frac_divider.sv
`timescale 1ns/100ps
`default_nettype none

module frac_divider #(
    parameter int INT_W  = 8,
    parameter int FRAC_W = 16
) (
    input  wire logic              i_clock,
    input  wire logic              i_rst_n,
    input  wire logic              i_tick,
    input  wire logic [INT_W-1:0]  i_int,
    input  wire logic [FRAC_W-1:0] i_frac,
    output logic                   o_tick
);
    logic [INT_W-1:0]  count;
    logic [FRAC_W-1:0] acc;
    logic              extra;

    wire [INT_W:0]  target   = {1'b0, i_int} + {{INT_W{1'b0}}, extra};
    wire            period   = ({1'b0, count} + (INT_W+1)'(1)) >= target;
    wire [FRAC_W:0] acc_sum  = {1'b0, acc} + {1'b0, i_frac};

    // Each output period is i_int or i_int+1 input ticks; the fraction
    // accumulator spreads the extra ticks so the mean ratio is exact.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            count  <= '0;
            acc    <= '0;
            extra  <= 1'b0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= i_tick && period;
            if (i_tick) begin
                if (period) begin
                    count <= '0;
                    acc   <= acc_sum[FRAC_W-1:0];
                    extra <= acc_sum[FRAC_W];
                end else begin
                    count <= count + INT_W'(1);
                end
            end
        end
    end

endmodule : frac_divider
`default_nettype wire

// File: src/system_clock_mode_control.sv
// Function
// RQ1 - Reset selects high-frequency RC source
// RQ2 - RC trim register, calibrated against crystal
// RQ3 - Radio ready only on crystal source
// RQ4 - Software-set crystal bias code
// RQ5 - Crystal failure falls back to RC, NMI
// RQ6 - Source select: 0 RC, 1 crystal
// RQ7 - Peripheral clock is half system clock
// RQ8 - CPU select: 0 peripheral, 1 system
// RQ9 - Four modes give documented clock ratios
// RQ10 - Flash busy forces 12 MHz processor clock
// RQ11 - Fast processor mode is reset default
// RQ12 - Fractional-N divider makes 1 kHz reference
// RQ13 - Digital clock may replace low crystal
// RQ14 - All switches happen at period boundaries; a crystal failure switches the source at once (the ctrl LF source select takes effect at once)
`timescale 1ns/100ps
`default_nettype none
`include "clock_mode_defines.svh"

module system_clock_mode_control
    import clock_mode_pkg::*;
#(
    parameter int FAIL_CYCLES = `XTAL_FAIL_CYCLES,
    parameter int CAL_WINDOW  = `CAL_WINDOW
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic [7:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    output logic [31:0]      o_readdata,
    output logic             o_waitrequest,
    input  wire logic        i_hf_rc_tick,
    input  wire logic        i_hf_crystal_tick,
    input  wire logic        i_lf_rc_tick,
    input  wire logic        i_lf_crystal_tick,
    input  wire logic        i_flash_busy,
    output logic             o_main_system_clock_tick,
    output logic             o_peripheral_clock_tick,
    output logic             o_processor_clock_tick,
    output logic             o_one_khz_reference_tick,
    output logic             o_crystal_enable,
    output logic [3:0]       o_crystal_bias,
    output logic [5:0]       o_hf_rc_trim,
    output logic             o_radio_clock_ok,
    output logic             o_nmi,
    output logic             o_irq
);
    ////////////////////////////////////////////////////////////////////////
    // Registers and bus slave.

    logic [3:0]           ctrl;
    logic [`INT_WIDTH-1:0] int_status;
    logic [`INT_WIDTH-1:0] int_mask;
    logic [3:0]           crystal_bias;
    logic [5:0]           hf_rc_trim;
    logic [7:0]           lf_int;
    logic [15:0]          lf_frac;
    logic [15:0]          cal_count;
    logic                 ack;

    main_system_clock_source_e active_src;
    cpu_mode_e      active_cpu;
    logic           flash_override;
    logic           pclk_phase;

    wire request = i_read || i_write;
    wire wr_ok   = i_write && ack;
    wire rd_load = i_read && !ack;

    wire sel_ctrl  = (i_address == `REG_CTRL);
    wire sel_stat  = (i_address == `REG_STATUS);
    wire sel_ist   = (i_address == `REG_INT_STATUS);
    wire sel_imask = (i_address == `REG_INT_MASK);
    wire sel_bias  = (i_address == `REG_XTAL_BIAS);
    wire sel_trim  = (i_address == `REG_HFRC_TRIM);
    wire sel_cal   = (i_address == `REG_CAL_COUNT);
    wire sel_lfdiv = (i_address == `REG_LF_DIV);

    wire crystal_healthy;

    wire [5:0] status_word = {
        crystal_healthy,
        o_radio_clock_ok,
        int_status[`INT_FAIL_BIT],
        flash_override,
        active_cpu == CPU_FAST,
        active_src == SRC_HF_CRYSTAL
    };

    // Unmapped offsets read as zero and drop writes, which leaves room for
    // later registers without any change visible to existing software.
    wire [31:0] read_mux =
        sel_ctrl  ? {28'h0000000, ctrl}                  :
        sel_stat  ? {26'h0000000, status_word}           :
        sel_ist   ? {30'h00000000, int_status}           :
        sel_imask ? {30'h00000000, int_mask}             :
        sel_bias  ? {28'h0000000, crystal_bias}          :
        sel_trim  ? {26'h0000000, hf_rc_trim}            :
        sel_cal   ? {16'h0000, cal_count}                :
        sel_lfdiv ? {8'h00, lf_frac, lf_int}             :
                    32'h00000000;

    // Every access is answered one cycle after it is presented.
    assign o_waitrequest = request && !ack;

    // The single wait state gives the read mux a whole cycle to settle
    // before the data are registered for the master.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ack        <= 1'b0;
            o_readdata <= 32'h00000000;
        end else begin
            ack <= request && !ack;
            if (rd_load)
                o_readdata <= read_mux;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ctrl         <= `CTRL_RESET;                           // RQ1 RQ11
            int_mask     <= '0;
            crystal_bias <= `XTAL_BIAS_RESET;
            hf_rc_trim   <= `HFRC_TRIM_RESET;
            lf_int       <= `LF_INT_RESET;
            lf_frac      <= `LF_FRAC_RESET;
        end else if (wr_ok) begin
            if (sel_ctrl)
                ctrl <= i_writedata[3:0];                          // RQ6 RQ8
            if (sel_imask)
                int_mask <= i_writedata[`INT_WIDTH-1:0];
            if (sel_bias)
                crystal_bias <= i_writedata[3:0];                  // RQ4
            if (sel_trim)
                hf_rc_trim <= i_writedata[5:0];                    // RQ2
            if (sel_lfdiv) begin
                lf_int  <= i_writedata[7:0];                       // RQ12
                lf_frac <= i_writedata[23:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Crystal supervision and clock switching.

    // The silence limit trades detection speed against false alarms on a
    // crystal whose duty cycle stretches a gap by a cycle or two.
    crystal_monitor #(
        .LIMIT     (FAIL_CYCLES)
    ) u_monitor (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_enable  (ctrl[`CTRL_XEN_BIT]),
        .i_tick    (i_hf_crystal_tick),
        .o_healthy (crystal_healthy)
    );

    wire on_crystal = (active_src == SRC_HF_CRYSTAL);
    wire fail_event = on_crystal && !crystal_healthy;              // RQ5
    // Turning the crystal off while it is selected counts as a failure:
    // the monitor reads a disabled crystal as expired, so the source
    // falls back at once rather than stalling on a silent input.

    // A latched failure keeps the crystal out until software clears it.
    // Without that hold a stuttering crystal would flap the source.
    wire want_crystal = ctrl[`CTRL_SRC_BIT] && crystal_healthy
                        && !int_status[`INT_FAIL_BIT];

    wire sys_tick  = on_crystal ? i_hf_crystal_tick : i_hf_rc_tick; // RQ6
    wire pclk_tick = sys_tick && pclk_phase;                       // RQ7
    wire boundary  = pclk_tick;                                    // RQ14

    wire next_src_crystal = boundary ? want_crystal : on_crystal;
    wire switch_event     = boundary && (want_crystal != on_crystal);

    // Selects move only at the end of a whole peripheral period, so a
    // voluntary switch never shortens a cycle; a crystal failure moves the source at once.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            active_src     <= SRC_HF_RC;                           // RQ1
            active_cpu     <= CPU_FAST;                            // RQ11
            flash_override <= 1'b0;
            pclk_phase     <= 1'b0;
        end else if (fail_event) begin
            active_src <= SRC_HF_RC;                               // RQ5
            pclk_phase <= 1'b0;
        end else begin
            if (sys_tick)
                pclk_phase <= !pclk_phase;                         // RQ7
            if (boundary) begin
                active_src     <= next_src_crystal ? SRC_HF_CRYSTAL
                                                   : SRC_HF_RC;    // RQ14
                active_cpu     <= ctrl[`CTRL_CPU_BIT] ? CPU_FAST
                                                      : CPU_NORMAL;
                flash_override <= i_flash_busy;                    // RQ10
            end
        end
    end

    // Under flash the processor gets 12 MHz: the system stream on RC,
    // the peripheral stream on the crystal.
    wire cpu_fast_tick = (active_cpu == CPU_FAST) ? sys_tick : pclk_tick;
    wire flash_tick    = on_crystal ? pclk_tick : sys_tick;        // RQ10
    wire cpu_tick      = flash_override ? flash_tick
                                        : cpu_fast_tick;           // RQ8 RQ9

    ////////////////////////////////////////////////////////////////////////
    // RC calibration against the crystal and the 1 kHz reference.

    localparam int CALW = $clog2(CAL_WINDOW + 1);
    logic [CALW-1:0] cal_xtal;
    logic [15:0]     cal_rc;
    wire             cal_done = (cal_xtal == CALW'(CAL_WINDOW));

    // Counts RC ticks over a fixed number of crystal ticks; software
    // compares the result with the ideal ratio and steps the trim.
    // Ticks in the cycle that closes a window open the next one, so no
    // edge is lost between windows.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || !crystal_healthy) begin
            cal_xtal  <= '0;
            cal_rc    <= '0;
            cal_count <= '0;
        end else if (cal_done) begin
            cal_count <= cal_rc;                                   // RQ2
            cal_xtal  <= CALW'(i_hf_crystal_tick);
            cal_rc    <= 16'(i_hf_rc_tick);
        end else begin
            if (i_hf_crystal_tick)
                cal_xtal <= cal_xtal + CALW'(1);
            if (i_hf_rc_tick)
                cal_rc <= cal_rc + 16'h0001;
        end
    end

    // The low-frequency pin may carry a digital clock instead of a crystal.
    wire lf_tick = ctrl[`CTRL_LF_BIT] ? i_lf_crystal_tick : i_lf_rc_tick; // RQ13
    wire one_khz_tick;

    // The ratio is software's to set; a zero integer part gives one output
    // per input tick rather than a stalled reference.
    frac_divider #(
        .INT_W   (8),
        .FRAC_W  (16)
    ) u_lf_div (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_tick  (lf_tick),
        .i_int   (lf_int),
        .i_frac  (lf_frac),
        .o_tick  (one_khz_tick)                                    // RQ12
    );

    ////////////////////////////////////////////////////////////////////////
    // Interrupts and registered outputs.

    wire [`INT_WIDTH-1:0] int_set   = {switch_event, fail_event};
    wire [`INT_WIDTH-1:0] int_clear = (wr_ok && sel_ist)
                                      ? i_writedata[`INT_WIDTH-1:0]
                                      : '0;

    // A new event in the cycle of its clear keeps the bit set.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n)
            int_status <= '0;
        else
            int_status <= (int_status & ~int_clear) | int_set;
    end

    // Outputs are registered so consumers see clean one-cycle pulses; the
    // price is one cycle of latency behind the source tick, two behind the low-frequency tick for the 1 kHz reference.
    wire radio_next = on_crystal && !fail_event;                   // RQ3
    wire nmi_next   = int_status[`INT_FAIL_BIT] | fail_event;      // RQ5
    wire irq_next   = |(int_status & int_mask);

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_main_system_clock_tick <= 1'b0;
            o_peripheral_clock_tick  <= 1'b0;
            o_processor_clock_tick   <= 1'b0;
            o_one_khz_reference_tick <= 1'b0;
            o_radio_clock_ok         <= 1'b0;
            o_nmi                    <= 1'b0;
            o_irq                    <= 1'b0;
        end else begin
            o_main_system_clock_tick <= sys_tick;
            o_peripheral_clock_tick  <= pclk_tick;
            o_processor_clock_tick   <= cpu_tick;
            o_one_khz_reference_tick <= one_khz_tick;
            o_radio_clock_ok         <= radio_next;                // RQ3
            o_nmi                    <= nmi_next;                  // RQ5
            o_irq                    <= irq_next;
        end
    end

    assign o_crystal_enable = ctrl[`CTRL_XEN_BIT];
    assign o_crystal_bias   = crystal_bias;                        // RQ4
    assign o_hf_rc_trim     = hf_rc_trim;

endmodule : system_clock_mode_control
`default_nettype wire

// File: test/clock_mode_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module clock_mode_assertions #(
    parameter int FAIL_CYCLES = 16,
    parameter int CAL_WINDOW  = 1024
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic i_hf_crystal_tick,
    input wire logic i_lf_rc_tick,
    input wire logic i_lf_crystal_tick,
    input wire logic i_flash_busy,
    input wire logic o_waitrequest,
    input wire logic o_main_system_clock_tick,
    input wire logic o_peripheral_clock_tick,
    input wire logic o_processor_clock_tick,
    input wire logic o_one_khz_reference_tick,
    input wire logic o_crystal_enable,
    input wire logic o_radio_clock_ok,
    input wire logic o_nmi,
    input wire logic o_irq
);
default clocking cb @(posedge i_clock); endclocking
default disable iff (!i_rst_n);
////////////////////////////////////////////////////////////////////////
// Gap saturates so a long crystal outage never wraps back to healthy.
logic [5:0] gap;
logic [1:0] since;
logic [1:0] fcnt;
always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
        gap   <= 6'h00;
        since <= 2'h0;
        fcnt  <= 2'h0;
    end else begin
        gap   <= i_hf_crystal_tick ? 6'h00 : gap + 6'(gap != 6'h3F);
        since <= o_peripheral_clock_tick ? 2'h0
               : since + 2'(o_main_system_clock_tick && since != 2'h3);
        fcnt  <= !i_flash_busy ? 2'h0
               : fcnt + 2'(o_peripheral_clock_tick && fcnt != 2'h3);
    end
end
////////////////////////////////////////////////////////////////////////
wait_one_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest) else $error("wait not one cycle");
wait_idle_a: assert property (!(i_read || i_write) |-> !o_waitrequest) else $error("wait without request");
reset_quiet_a: assert property (disable iff (1'b0) !i_rst_n |=> !o_nmi && !o_irq && !o_radio_clock_ok && !o_main_system_clock_tick) else $error("outputs busy in reset");
fail_back_a: assert property (gap > FAIL_CYCLES + 3 |-> !o_radio_clock_ok) else $error("no failover");
fail_nmi_a: assert property ($fell(o_radio_clock_ok) && gap >= FAIL_CYCLES - 1 |-> ##[0:2] o_nmi) else $error("failover without nmi");
per_half_a: assert property (o_peripheral_clock_tick |-> o_main_system_clock_tick && since inside {[1:2]}) else $error("peripheral not half");
cpu_on_sys_a: assert property (o_processor_clock_tick |-> o_main_system_clock_tick) else $error("cpu tick off grid");
per_in_cpu_a: assert property (o_peripheral_clock_tick |-> o_processor_clock_tick) else $error("cpu slower than peripheral");
flash_cpu_a: assert property (fcnt >= 2'h2 |-> o_processor_clock_tick == (o_radio_clock_ok ? o_peripheral_clock_tick : o_main_system_clock_tick)) else $error("flash override wrong");
radio_xtal_a: assert property (o_radio_clock_ok |-> o_crystal_enable) else $error("radio ok without crystal");
sys_source_a: assert property (o_main_system_clock_tick && o_radio_clock_ok && $past(o_radio_clock_ok) |-> $past(i_hf_crystal_tick)) else $error("system tick not from crystal");
ref_lf_a: assert property (o_one_khz_reference_tick |-> $past(i_lf_rc_tick || i_lf_crystal_tick, 2)) else $error("reference off lf tick");
endmodule : clock_mode_assertions
bind system_clock_mode_control clock_mode_assertions #(
    .FAIL_CYCLES(FAIL_CYCLES), .CAL_WINDOW(CAL_WINDOW)
) chk_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_read(i_read),
    .i_write(i_write), .i_hf_crystal_tick(i_hf_crystal_tick),
    .i_lf_rc_tick(i_lf_rc_tick), .i_lf_crystal_tick(i_lf_crystal_tick),
    .i_flash_busy(i_flash_busy), .o_waitrequest(o_waitrequest),
    .o_main_system_clock_tick(o_main_system_clock_tick),
    .o_peripheral_clock_tick(o_peripheral_clock_tick),
    .o_processor_clock_tick(o_processor_clock_tick),
    .o_one_khz_reference_tick(o_one_khz_reference_tick),
    .o_crystal_enable(o_crystal_enable),
    .o_radio_clock_ok(o_radio_clock_ok), .o_nmi(o_nmi), .o_irq(o_irq));
`default_nettype wire

// File: test/clock_consumer_model.sv
`timescale 1ns/100ps
`default_nettype none
module clock_consumer_model (
    input  wire logic        i_clock,
    input  wire logic        i_clear,
    input  wire logic [3:0]  i_ticks,
    input  wire logic [3:0]  i_pin_period,
    output logic             o_pin_tick,
    output logic [15:0]      o_count [4]
);
logic [3:0] pcnt = 4'h0;
// A zero period keeps the pin clock still, as an unused pin would be.
always_ff @(posedge i_clock) begin
    pcnt       <= (pcnt >= i_pin_period - 4'h1) ? 4'h0 : pcnt + 4'h1;
    o_pin_tick <= (i_pin_period != 4'h0) && (pcnt == 4'h0);
    for (int k = 0; k < 4; k++) begin
        o_count[k] <= i_clear ? 16'h0 : o_count[k] + 16'(i_ticks[k]);
    end
end
endmodule : clock_consumer_model
`default_nettype wire

// File: test/system_clock_mode_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "clock_mode_defines.svh"
module system_clock_mode_control_bench;
logic        clk, rst_n, rd, wr, rc, xt, lfr, lfp, fl, clr, xt_on;
logic        wq, sys, per, cpu, ref1k, xen, radio, nmi, irq;
logic [7:0]  adr;
logic [31:0] wd, rdat;
logic [3:0]  bias, obias, pper;
logic [5:0]  trim, otrim;
logic [1:0]  lc;
logic [15:0] cnt [4];
logic [31:0] eq [$];
logic [31:0] mq [$];
int          n_fail, checks_done;
system_clock_mode_control #(.FAIL_CYCLES(16), .CAL_WINDOW(16)) dut_u (
    .i_clock(clk), .i_rst_n(rst_n), .i_address(adr), .i_read(rd),
    .i_write(wr), .i_writedata(wd), .o_readdata(rdat), .o_waitrequest(wq),
    .i_hf_rc_tick(rc), .i_hf_crystal_tick(xt), .i_lf_rc_tick(lfr),
    .i_lf_crystal_tick(lfp), .i_flash_busy(fl),
    .o_main_system_clock_tick(sys), .o_peripheral_clock_tick(per),
    .o_processor_clock_tick(cpu), .o_one_khz_reference_tick(ref1k),
    .o_crystal_enable(xen), .o_crystal_bias(obias), .o_hf_rc_trim(otrim),
    .o_radio_clock_ok(radio), .o_nmi(nmi), .o_irq(irq));
clock_consumer_model far_u (.i_clock(clk), .i_clear(clr),
    .i_ticks({ref1k, cpu, per, sys}), .i_pin_period(pper),
    .o_pin_tick(lfp), .o_count(cnt));
initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
end
always @(posedge clk) begin
    rc  <= 1'b1;
    xt  <= xt_on & ~xt;
    lc  <= lc + 2'h1;
    lfr <= (lc == 2'h3);
end
////////////////////////////////////////////////////////////////////////
task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
        n_fail++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
endtask : check
task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask : complete_run
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    wd  <= d;
    rd  <= ~w;
    wr  <= w;
    n = 0;
    do begin
        @(posedge clk);
        n++;
    end while (wq !== 1'b0 && n < 40);
    if (wq !== 1'b0) begin
        n_fail++;
        complete_run();
    end
    rd <= 1'b0;
    wr <= 1'b0;
endtask : bus
task automatic rdx(input logic [7:0] a, input logic [31:0] e,
                   input logic [31:0] m = 32'hFFFFFFFF);
    eq.push_back(e);
    mq.push_back(m);
    bus(1'b0, a, 32'h0);
endtask : rdx
task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
endtask : idle
// Settling first lets a pending select reach its peripheral boundary.
task automatic cnts(input int n, input logic [15:0] es, ep, ec);
    repeat (8) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    idle(n);
    check(32'(cnt[0]), 32'(es));
    check(32'(cnt[1]), 32'(ep));
    check(32'(cnt[2]), 32'(ec));
endtask : cnts
always @(posedge clk) begin
    if (rd && wq === 1'b0) begin
        check(rdat & mq.pop_front(), eq.pop_front());
    end
end
initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
end
////////////////////////////////////////////////////////////////////////
initial begin
    {rst_n, rd, wr, rc, xt, lfr, fl, xt_on, lc} = '0;
    {adr, wd, pper, clr} = '0;
    n_fail = 0;
    checks_done = 0;
    void'($urandom(32'h1DE5F2A3));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdx(`REG_CTRL, 32'h2);
    rdx(`REG_STATUS, 32'h2);
    rdx(`REG_XTAL_BIAS, 32'hF);
    rdx(`REG_HFRC_TRIM, 32'h20);
    rdx(`REG_INT_MASK, 32'h0);
    rdx(`REG_LF_DIV, 32'hA);
    rdx(8'h20, 32'h0);
    $display("test reset done");
    bias = 4'($urandom());
    trim = 6'($urandom());
    bus(1'b1, `REG_XTAL_BIAS, 32'(bias));
    bus(1'b1, `REG_HFRC_TRIM, 32'(trim));
    bus(1'b1, `REG_STATUS, 32'hFF);
    rdx(`REG_XTAL_BIAS, 32'(bias));
    rdx(`REG_HFRC_TRIM, 32'(trim));
    rdx(`REG_STATUS, 32'h2);
    check(32'(obias), 32'(bias));
    check(32'(otrim), 32'(trim));
    $display("test registers done");
    cnts(40, 16'h28, 16'h14, 16'h28);
    bus(1'b1, `REG_CTRL, 32'h0);
    cnts(40, 16'h28, 16'h14, 16'h14);
    @(posedge clk) fl <= 1'b1;
    cnts(40, 16'h28, 16'h14, 16'h28);
    @(posedge clk) fl <= 1'b0;
    $display("test rc modes done");
    xt_on <= 1'b1;
    bus(1'b1, `REG_CTRL, 32'hA);
    bus(1'b1, `REG_CTRL, 32'hB);
    idle(20);
    rdx(`REG_STATUS, 32'h33);
    check(32'(radio), 32'h1);
    check(32'(irq), 32'h0);
    cnts(40, 16'h14, 16'h0A, 16'h14);
    @(posedge clk) fl <= 1'b1;
    cnts(40, 16'h14, 16'h0A, 16'h0A);
    rdx(`REG_CAL_COUNT, 32'h20);
    @(posedge clk) fl <= 1'b0;
    bus(1'b1, `REG_INT_MASK, 32'h2);
    idle(3);
    check(32'(irq), 32'h1);
    bus(1'b1, `REG_INT_STATUS, 32'h2);
    idle(3);
    check(32'(irq), 32'h0);
    $display("test crystal done");
    xt_on <= 1'b0;
    idle(30);
    check(32'(nmi), 32'h1);
    check(32'(radio), 32'h0);
    rdx(`REG_INT_STATUS, 32'h1, 32'h1);
    rdx(`REG_STATUS, 32'h8, 32'h19);
    rdx(`REG_CAL_COUNT, 32'h0);
    cnts(40, 16'h28, 16'h14, 16'h28);
    bus(1'b1, `REG_INT_STATUS, 32'h3);
    idle(3);
    check(32'(nmi), 32'h0);
    $display("test failover done");
    bus(1'b1, `REG_CTRL, 32'h2);
    bus(1'b1, `REG_LF_DIV, 32'h5);
    idle(60);
    cnts(200, 16'hC8, 16'h64, 16'hC8);
    check(32'(cnt[3]), 32'hA);
    pper <= 4'h3;
    bus(1'b1, `REG_CTRL, 32'h6);
    idle(60);
    cnts(150, 16'h96, 16'h4B, 16'h96);
    check(32'(cnt[3]), 32'hA);
    $display("test reference done");
    complete_run();
end
endmodule : system_clock_mode_control_bench
`default_nettype wire
